// ### common/ahcf_pkg.sv
// Shared constants and types for the ASCII host command framer
package ahcf_pkg;
  // ---------------------------------------------------------------
  // Character codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CH_LF    = 8'h0A;
  localparam logic [7:0] CH_CR    = 8'h0D;
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_COMMA = 8'h2C;
  localparam logic [7:0] CH_DOT   = 8'h2E;
  localparam logic [7:0] CH_ZERO  = 8'h30;
  localparam logic [7:0] CH_E     = 8'h45;
  localparam logic [7:0] CH_PLUS  = 8'h2B;
  localparam logic [7:0] CH_MINUS = 8'h2D;
  localparam logic [7:0] CH_LOW_A = 8'h61;
  localparam logic [7:0] CH_LOW_Z = 8'h7A;
  localparam logic [7:0] CASE_BIT = 8'h20;
  localparam logic [7:0] STAT_BIT6 = 8'h40;
  // ---------------------------------------------------------------
  // Token sizes and reply buffer
  // ---------------------------------------------------------------
  localparam int CMD_CHARS = 5;
  localparam int MOD_CHARS = 3;
  localparam int BUF_DEPTH = 10;
  localparam logic [3:0] LEN_OK      = 4'h4;
  localparam logic [3:0] LEN_INVALID = 4'h9;
  localparam logic [3:0] LEN_PRESS   = 4'hA;
  localparam logic [3:0] LEN_SINGLE  = 4'h3;
  // ---------------------------------------------------------------
  // Reply value field layout
  // ---------------------------------------------------------------
  localparam int RV_M0  = 17;
  localparam int RV_M1  = 13;
  localparam int RV_M2  = 9;
  localparam int RV_NEG = 8;
  localparam int RV_E1  = 4;
  localparam int RV_E0  = 0;
  // ---------------------------------------------------------------
  // Reply kinds and states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    RK_OK = 3'h0, RK_INVALID = 3'h1, RK_PRESS = 3'h2, RK_DIGIT = 3'h3, RK_BYTE = 3'h4
  } ahcf_kind_t;
  typedef enum logic [1:0] {
    ST_PARSE = 2'h0, ST_ISSUE = 2'h1, ST_REPLY = 2'h3, ST_SEND = 2'h2
  } ahcf_state_t;
  typedef enum logic [2:0] {
    PS_LEAD = 3'h0, PS_CMD = 3'h1, PS_SEP = 3'h3, PS_MOD = 3'h2, PS_TAIL = 3'h6
  } ahcf_pstate_t;
endpackage : ahcf_pkg

// ### src/ahcf_framer.sv
// Host message framer and reply formatter
`timescale 1ns/100ps
module ahcf_framer (
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic        gpib_mode,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_eoi,
  output logic             rx_ready,
  output logic             cmd_valid,
  output logic [39:0]      cmd_token,
  output logic [23:0]      mod_token,
  output logic             mod_present,
  input  wire logic        rep_valid,
  input  wire logic [2:0]  rep_kind,
  input  wire logic [20:0] rep_value,
  output logic             rep_ready,
  output logic             tx_valid,
  output logic [7:0]       tx_data,
  output logic             tx_eoi,
  input  wire logic        tx_ready
);
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] to_upper(input logic [7:0] c);
    to_upper = (c >= ahcf_pkg::CH_LOW_A && c <= ahcf_pkg::CH_LOW_Z) ?
               (c & ~ahcf_pkg::CASE_BIT) : c;
  endfunction : to_upper

  function automatic logic [7:0] dig(input logic [3:0] d);
    dig = ahcf_pkg::CH_ZERO | {4'h0, d};
  endfunction : dig

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  ahcf_pkg::ahcf_state_t  st_q;
  ahcf_pkg::ahcf_pstate_t ps_q;
  logic [39:0] cmd_q;
  logic [23:0] mod_q;
  logic [2:0]  cmd_len_q;
  logic [1:0]  mod_len_q;
  logic        mod_present_q;
  logic [7:0]  buf_q [ahcf_pkg::BUF_DEPTH];
  logic [7:0]  buf_d [ahcf_pkg::BUF_DEPTH];
  logic [3:0]  len_q;
  logic [3:0]  len_d;
  logic [3:0]  idx_q;
  logic        rx_ready_q;
  logic        cmd_valid_q;
  logic        rep_ready_q;
  logic        tx_valid_q;
  logic [7:0]  tx_data_q;
  logic        tx_eoi_q;

  // ---------------------------------------------------------------
  // Character decode
  // ---------------------------------------------------------------
  wire       take     = rx_valid & rx_ready_q;
  wire [7:0] up       = to_upper(rx_data);
  wire       is_lf    = (rx_data == ahcf_pkg::CH_LF);
  wire       is_cr    = (rx_data == ahcf_pkg::CH_CR);
  wire       is_space = (rx_data == ahcf_pkg::CH_SPACE);
  wire       is_sep   = is_space | (rx_data == ahcf_pkg::CH_COMMA) | is_cr;
  wire       end_msg  = take & (is_lf | (gpib_mode & rx_eoi));
  wire       is_text  = take & ~is_lf;
  wire       load     = rep_valid & rep_ready_q;
  wire       last     = (idx_q == len_q - 4'h1);
  wire [3:0] idx_nx   = idx_q + 4'h1;

  // ---------------------------------------------------------------
  // Reply image
  // ---------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < ahcf_pkg::BUF_DEPTH; i++) begin
      buf_d[i] = ahcf_pkg::CH_LF;
    end
    len_d = ahcf_pkg::LEN_SINGLE;
    case (rep_kind)
      ahcf_pkg::RK_OK: begin
        buf_d[0] = "O";
        buf_d[1] = "K";
        buf_d[2] = ahcf_pkg::CH_CR;
        len_d    = ahcf_pkg::LEN_OK;
      end
      ahcf_pkg::RK_INVALID: begin
        buf_d[0] = "I";
        buf_d[1] = "N";
        buf_d[2] = "V";
        buf_d[3] = "A";
        buf_d[4] = "L";
        buf_d[5] = "I";
        buf_d[6] = "D";
        buf_d[7] = ahcf_pkg::CH_CR;
        len_d    = ahcf_pkg::LEN_INVALID;
      end
      ahcf_pkg::RK_PRESS: begin
        buf_d[0] = dig(rep_value[ahcf_pkg::RV_M0 +: 4]);
        buf_d[1] = ahcf_pkg::CH_DOT;
        buf_d[2] = dig(rep_value[ahcf_pkg::RV_M1 +: 4]);
        buf_d[3] = dig(rep_value[ahcf_pkg::RV_M2 +: 4]);
        buf_d[4] = ahcf_pkg::CH_E;
        buf_d[5] = rep_value[ahcf_pkg::RV_NEG] ? ahcf_pkg::CH_MINUS : ahcf_pkg::CH_PLUS;
        buf_d[6] = dig(rep_value[ahcf_pkg::RV_E1 +: 4]);
        buf_d[7] = dig(rep_value[ahcf_pkg::RV_E0 +: 4]);
        buf_d[8] = ahcf_pkg::CH_CR;
        len_d    = ahcf_pkg::LEN_PRESS;
      end
      ahcf_pkg::RK_BYTE: begin
        buf_d[0] = ahcf_pkg::STAT_BIT6 | {2'b00, rep_value[5:0]};
        buf_d[1] = ahcf_pkg::CH_CR;
      end
      default: begin
        buf_d[0] = dig(rep_value[3:0]);
        buf_d[1] = ahcf_pkg::CH_CR;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Inbound tokeniser
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst || (st_q == ahcf_pkg::ST_SEND && tx_valid_q && tx_ready && last)) begin
      ps_q      <= ahcf_pkg::PS_LEAD;
      cmd_q     <= 40'h0;
      mod_q     <= 24'h0;
      cmd_len_q <= 3'h0;
      mod_len_q <= 2'h0;
      mod_present_q <= 1'b0;
    end else if (st_q == ahcf_pkg::ST_PARSE && is_text) begin
      case (ps_q)
        ahcf_pkg::PS_LEAD: if (!is_space && !is_cr) begin
          cmd_q     <= {cmd_q[31:0], up};
          cmd_len_q <= 3'h1;
          ps_q      <= ahcf_pkg::PS_CMD;
        end
        ahcf_pkg::PS_CMD: if (is_sep) begin
          ps_q <= ahcf_pkg::PS_SEP;
        end else if (cmd_len_q < 3'(ahcf_pkg::CMD_CHARS)) begin
          cmd_q     <= {cmd_q[31:0], up};
          cmd_len_q <= cmd_len_q + 3'h1;
        end
        ahcf_pkg::PS_SEP: if (!is_sep) begin
          mod_q     <= {mod_q[15:0], up};
          mod_len_q <= 2'h1;
          mod_present_q <= 1'b1;
          ps_q      <= ahcf_pkg::PS_MOD;
        end
        ahcf_pkg::PS_MOD: if (is_sep) begin
          ps_q <= ahcf_pkg::PS_TAIL;
        end else if (mod_len_q < 2'(ahcf_pkg::MOD_CHARS)) begin
          mod_q     <= {mod_q[15:0], up};
          mod_len_q <= mod_len_q + 2'h1;
        end
        default: ps_q <= ahcf_pkg::PS_TAIL;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Message and reply sequencing
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_q        <= ahcf_pkg::ST_PARSE;
      rx_ready_q  <= 1'b1;
      cmd_valid_q <= 1'b0;
      rep_ready_q <= 1'b0;
      tx_valid_q  <= 1'b0;
      tx_data_q   <= 8'h00;
      tx_eoi_q    <= 1'b0;
      idx_q       <= 4'h0;
      len_q       <= 4'h0;
      for (int i = 0; i < ahcf_pkg::BUF_DEPTH; i++) begin
        buf_q[i] <= 8'h00;
      end
    end else begin
      cmd_valid_q <= 1'b0;
      case (st_q)
        ahcf_pkg::ST_PARSE: if (end_msg) begin
          rx_ready_q <= 1'b0;
          st_q       <= ahcf_pkg::ST_ISSUE;
        end
        ahcf_pkg::ST_ISSUE: begin
          cmd_valid_q <= 1'b1;
          rep_ready_q <= 1'b1;
          st_q        <= ahcf_pkg::ST_REPLY;
        end
        ahcf_pkg::ST_REPLY: if (load) begin
          buf_q       <= buf_d;
          len_q       <= len_d;
          idx_q       <= 4'h0;
          rep_ready_q <= 1'b0;
          tx_valid_q  <= 1'b1;
          tx_data_q   <= buf_d[0];
          st_q        <= ahcf_pkg::ST_SEND;
        end
        ahcf_pkg::ST_SEND: if (tx_ready) begin
          if (last) begin
            tx_valid_q <= 1'b0;
            tx_eoi_q   <= 1'b0;
            rx_ready_q <= 1'b1;
            st_q       <= ahcf_pkg::ST_PARSE;
          end else begin
            idx_q     <= idx_nx;
            tx_data_q <= buf_q[idx_nx];
            tx_eoi_q  <= gpib_mode && (idx_nx == len_q - 4'h1);
          end
        end
        default: st_q <= ahcf_pkg::ST_PARSE;
      endcase
    end
  end

  assign rx_ready    = rx_ready_q;
  assign cmd_valid   = cmd_valid_q;
  assign cmd_token   = cmd_q;
  assign mod_token   = mod_q;
  assign mod_present = mod_present_q;
  assign rep_ready   = rep_ready_q;
  assign tx_valid    = tx_valid_q;
  assign tx_data     = tx_data_q;
  assign tx_eoi      = tx_eoi_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  a_lf_ends_msg: assert property (take && is_lf |=> ##1 cmd_valid)
    else $error("line-feed did not end the message");
  a_eoi_ends_msg: assert property (take && gpib_mode && rx_eoi |=> ##1 cmd_valid)
    else $error("EOI character did not end the message");
  a_lead_skip: assert property (take && is_space && ps_q == ahcf_pkg::PS_LEAD
    && st_q == ahcf_pkg::ST_PARSE |=> ps_q == ahcf_pkg::PS_LEAD && cmd_len_q == 3'h0)
    else $error("leading space entered the command");
  a_tail_drop: assert property (take && !is_lf && ps_q == ahcf_pkg::PS_TAIL
    |=> $stable(cmd_q) && $stable(mod_q))
    else $error("trailing text changed the tokens");
  a_upper_only: assert property (take && ps_q == ahcf_pkg::PS_LEAD
    && rx_data >= ahcf_pkg::CH_LOW_A && rx_data <= ahcf_pkg::CH_LOW_Z
    |=> cmd_q[7:0] == ($past(rx_data) ^ ahcf_pkg::CASE_BIT))
    else $error("lower case letter not folded");
  a_one_reply: assert property (cmd_valid |=> !cmd_valid && !rx_ready)
    else $error("second message taken before reply");
  a_reply_late: assert property (tx_valid |-> !rx_ready && st_q == ahcf_pkg::ST_SEND)
    else $error("reply overlaps inbound message");
  a_eoi_on_lf: assert property (tx_valid && gpib_mode && tx_data == ahcf_pkg::CH_LF
    |-> tx_eoi)
    else $error("closing line-feed without EOI");
  a_eoi_only_lf: assert property (tx_eoi |-> tx_valid && tx_data == ahcf_pkg::CH_LF)
    else $error("EOI on a byte other than line-feed");
  a_ok_token: assert property (load && rep_kind == ahcf_pkg::RK_OK
    |=> tx_data == "O" && len_q == ahcf_pkg::LEN_OK)
    else $error("OK reply malformed");
  a_press_shape: assert property (load && rep_kind == ahcf_pkg::RK_PRESS
    |=> buf_q[1] == ahcf_pkg::CH_DOT && buf_q[4] == ahcf_pkg::CH_E)
    else $error("pressure reply malformed");
  a_status_bit6: assert property (load && rep_kind == ahcf_pkg::RK_BYTE |=> tx_data[6])
    else $error("status byte lacks bit 6");

  c_press_reply: cover property (load && rep_kind == ahcf_pkg::RK_PRESS);
  c_eoi_message: cover property (end_msg && !is_lf);
  c_invalid_reply: cover property (load && rep_kind == ahcf_pkg::RK_INVALID);
endmodule : ahcf_framer

// ### bench/ahcf_host_model.sv
// Host computer model that sinks reply bytes from the framer
`timescale 1ns/100ps
module ahcf_host_model (
  input  wire logic       ref_clk,
  input  wire logic       srst,
  input  wire logic       slow,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_eoi,
  output logic            tx_ready
);
  // ---------------------------------------------------------------
  // Reply capture
  // ---------------------------------------------------------------
  logic [7:0] got_q[$];
  logic       eoi_q[$];
  initial tx_ready = 1'h0;
  always @(posedge ref_clk) begin
    if (tx_valid === 1'h1 && tx_ready === 1'h1) begin
      got_q.push_back(tx_data);
      eoi_q.push_back(tx_eoi);
    end
    tx_ready <= srst ? 1'h0 : (slow ? ~tx_ready : 1'h1);
  end
endmodule : ahcf_host_model

// ### bench/tb_ascii_host_command_framer.sv
// Self-checking testbench for the host message framer
`timescale 1ns/100ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fails++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_ascii_host_command_framer;
  logic        ref_clk = 1'h0, srst = 1'h1, gpib_mode = 1'h0, slow = 1'h0;
  logic        rx_valid = 1'h0, rx_eoi = 1'h0, rep_valid = 1'h0;
  logic [7:0]  rx_data = 8'h00;
  logic [2:0]  rep_kind = 3'h0;
  logic [20:0] rep_value = 21'h0;
  logic        rx_ready, cmd_valid, mod_present, rep_ready, tx_valid, tx_eoi, tx_ready;
  logic [39:0] cmd_token;
  logic [23:0] mod_token;
  logic [7:0]  tx_data;
  int          fails = 0, num_checks = 0, cyc = 0;
  always #5 ref_clk = ~ref_clk;
  ahcf_framer i_dut (.ref_clk(ref_clk), .srst(srst), .gpib_mode(gpib_mode),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_eoi(rx_eoi), .rx_ready(rx_ready),
    .cmd_valid(cmd_valid), .cmd_token(cmd_token), .mod_token(mod_token),
    .mod_present(mod_present), .rep_valid(rep_valid), .rep_kind(rep_kind),
    .rep_value(rep_value), .rep_ready(rep_ready), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_eoi(tx_eoi), .tx_ready(tx_ready));
  ahcf_host_model i_host (.ref_clk(ref_clk), .srst(srst), .slow(slow),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_eoi(tx_eoi), .tx_ready(tx_ready));
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic summarize;
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize
  function automatic logic [39:0] tok(input string s);
    logic [39:0] t;
    t = 40'h0;
    foreach (s[i]) t = {t[31:0], s[i]};
    return t;
  endfunction : tok
  task automatic run(input string msg, input bit eoi, input string cmd, input string md,
                     input logic [2:0] kind, input logic [20:0] val, input string rep);
    int          n;
    logic [39:0] t;
    i_host.got_q.delete();
    i_host.eoi_q.delete();
    foreach (msg[i]) begin
      rx_valid <= 1'h1;
      rx_data  <= msg[i];
      rx_eoi   <= eoi && (i == msg.len() - 1);
      n = 0;
      do begin
        @(posedge ref_clk);
        n++;
        `CHK(tx_valid, 1'h0)
      end while (rx_ready !== 1'h1 && n < 50);
      `CHK(rx_ready, 1'h1)
    end
    rx_valid <= 1'h0;
    rx_eoi   <= 1'h0;
    n = 0;
    while (cmd_valid !== 1'h1 && n < 20) begin
      @(posedge ref_clk);
      n++;
    end
    t = tok(md);
    `CHK(cmd_valid, 1'h1)
    `CHK(cmd_token, tok(cmd))
    `CHK(mod_token, t[23:0])
    `CHK(mod_present, md.len() > 0)
    rep_valid <= 1'h1;
    rep_kind  <= kind;
    rep_value <= val;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (rep_ready !== 1'h1 && n < 20);
    `CHK(rep_ready, 1'h1)
    rep_valid <= 1'h0;
    n = 0;
    while (i_host.got_q.size() < rep.len() && n < 300) begin
      @(posedge ref_clk);
      n++;
    end
    repeat (10) @(posedge ref_clk);
    `CHK(i_host.got_q.size(), rep.len())
    foreach (rep[i]) begin
      `CHK(i_host.got_q[i], rep[i])
      `CHK(i_host.eoi_q[i], gpib_mode && i == rep.len() - 1)
    end
    `CHK(rx_ready, 1'h1)
  endtask : run
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_crlf;
    run("pr1 L\r\n", 0, "PR1", "L", ahcf_pkg::RK_OK, 21'h0, "OK\r\n");
  endtask : t_crlf
  task automatic t_sep;
    run("  ig1,, on\n", 0, "IG1", "ON", ahcf_pkg::RK_INVALID, 21'h0, "INVALID\r\n");
  endtask : t_sep
  task automatic t_press;
    gpib_mode <= 1'h1;
    slow      <= 1'h1;
    run("ds cg1 xyz\r\n", 0, "DS", "CG1", ahcf_pkg::RK_PRESS,
        {4'h1, 4'h2, 4'h5, 1'h1, 4'h0, 4'h3}, "1.25E-03\r\n");
  endtask : t_press
  task automatic t_eoi;
    run("dgs", 1, "DGS", "", ahcf_pkg::RK_DIGIT, 21'h1, "1\r\n");
  endtask : t_eoi
  task automatic t_reset;
    rx_valid <= 1'h1;
    rx_data  <= "x";
    @(posedge ref_clk);
    srst     <= 1'h1;
    rx_valid <= 1'h0;
    repeat (2) @(posedge ref_clk);
    srst <= 1'h0;
    @(posedge ref_clk);
    `CHK(rx_ready, 1'h1)
    `CHK({cmd_valid, rep_ready, tx_valid, tx_eoi, mod_present}, 5'h00)
    `CHK(cmd_token, 40'h0)
  endtask : t_reset
  task automatic t_byte;
    gpib_mode <= 1'h0;
    run("PCS B\n", 0, "PCS", "B", ahcf_pkg::RK_BYTE, 21'h07, "G\r\n");
  endtask : t_byte
  task automatic t_plus;
    slow <= 1'h0;
    run("Ds,Ig\r\n", 0, "DS", "IG", ahcf_pkg::RK_PRESS,
        {4'h9, 4'h9, 4'h9, 1'h0, 4'h0, 4'h9}, "9.99E+09\r\n");
  endtask : t_plus
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      summarize();
    end
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    srst <= 1'h0;
    @(posedge ref_clk);
    t_crlf();
    t_sep();
    t_press();
    t_eoi();
    t_reset();
    t_byte();
    t_plus();
    summarize();
  end
endmodule : tb_ascii_host_command_framer
